//--- hw/ieoc_defs.svh
/*
 Constants of the basic-access signalling block: message identifiers,
 message codes, register offsets, field positions and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef IEOC_DEFS_SVH
`define IEOC_DEFS_SVH

// ------------------------------------------------------------
// Message identifiers and layout
// ------------------------------------------------------------
`define IEOC_ID_REQ 8'h14
`define IEOC_ID_RSP 8'h94
`define IEOC_OCT2_PAD 4'h0

// ------------------------------------------------------------
// Request codes
// ------------------------------------------------------------
`define IEOC_C_RST 8'h00
`define IEOC_C_L2R 8'h01
`define IEOC_C_DEACT_INT 8'h02
`define IEOC_C_COLD 8'h03
`define IEOC_C_SB_ON 8'h10
`define IEOC_C_SB_OFF 8'h11
`define IEOC_C_SB_UP 8'h12
`define IEOC_C_SB_DOWN 8'h13
`define IEOC_C_HOLD 8'h30
`define IEOC_C_LP2 8'h31
`define IEOC_C_LPB1 8'h32
`define IEOC_C_LPB2 8'h33
`define IEOC_C_RTN 8'h3f

// ------------------------------------------------------------
// Response code parts
// ------------------------------------------------------------
`define IEOC_RSP_BIT 8'h80
`define IEOC_SFAIL_NIB 4'hd
`define IEOC_OK_NIB 4'hb
`define IEOC_FAIL_NIB 4'hf
`define IEOC_R_UTC 8'hf4

// ------------------------------------------------------------
// Register offsets, control fields and reset value
// ------------------------------------------------------------
`define IEOC_A_CTRL 8'h00
`define IEOC_A_STAT 8'h04
`define IEOC_A_EVT 8'h08
`define IEOC_A_TXC 8'h0c
`define IEOC_A_MAP 8'h10
`define IEOC_CF_FSC 3
`define IEOC_CF_MPAIR 4
`define IEOC_CTRL_RST 11'h001
`define IEOC_NBA_FSC 3'h4

`endif

//--- hw/ieoc_pkg.sv
/*
 Types of the basic-access signalling block.
 Assumes no other file; its state encodings are given here.
*/
`default_nettype none

package ieoc_pkg;

	// Transmit octet sequencer, Gray coded along its path.
	typedef enum logic [1:0] {
		tx_idle = 2'h0,
		tx_id = 2'h1,
		tx_ba = 2'h3,
		tx_code = 2'h2
	} ieoc_tx_e;

	typedef logic [3:0] ieoc_ba_t;

	// One parsed three-octet message.
	typedef struct packed {
		logic [7:0] id;
		ieoc_ba_t ba;
		logic [7:0] code;
	} ieoc_msg_s;

endpackage

`default_nettype wire

//--- hw/ieoc_msg_if.sv
/*
 Carrier of parsed messages from the octet parser to the controller.
 Assumes the source drives valid as a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none

interface ieoc_msg_if;
	logic valid;
	ieoc_pkg::ieoc_msg_s msg;
	modport src (output valid, output msg);
	modport dst (input valid, input msg);
endinterface

`default_nettype wire

//--- hw/ieoc_parse.sv
/*
 Receive parser: gathers three octets into one message.
 Assumes rx_sof marks the first octet of each message.
*/
`timescale 1ns/1ps
`default_nettype none

module ieoc_parse (
	input wire logic pclk, // Bus clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic [7:0] rx_data, // Received octet.
	input wire logic rx_valid, // Octet strobe.
	input wire logic rx_sof, // First octet of a message.
	ieoc_msg_if.src mo // Parsed message.
);

	logic [1:0] cnt_reg;
	logic vld_reg;
	ieoc_pkg::ieoc_msg_s msg_reg;

	// Octet counter; low nibble of octet two is dropped.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= 2'h0;
			vld_reg <= 1'b0;
			msg_reg <= '0;
		end
		else
		begin
			vld_reg <= 1'b0;
			if (rx_valid && rx_sof)
			begin
				msg_reg.id <= rx_data;
				cnt_reg <= 2'h1;
			end
			else if (rx_valid && cnt_reg == 2'h1)
			begin
				msg_reg.ba <= rx_data[7:4]; // R25
				cnt_reg <= 2'h2;
			end
			else if (rx_valid && cnt_reg == 2'h2)
			begin
				msg_reg.code <= rx_data;
				vld_reg <= 1'b1;
				cnt_reg <= 2'h0;
			end
		end
	end

	// Message handed on as a registered pulse.
	assign mo.valid = vld_reg;
	assign mo.msg = msg_reg;

endmodule

`default_nettype wire

//--- hw/ieoc_slotmap.sv
/*
 Time slot map: places one basic access in the payload sub-block.
 Assumes sel below nba and pairs_m1 giving M minus one.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ieoc_defs.svh"

module ieoc_slotmap (
	input wire logic fsc, // Fast signalling channel in Z1.
	input wire logic mpair, // M-pair operation.
	input wire logic [1:0] pairs_m1, // Pair count minus one.
	input wire logic [2:0] nba, // Accesses carried.
	input wire logic [2:0] sel, // Access index, zero based.
	output logic [7:0] b1, // First bearer slot number.
	output logic [7:0] b2, // Second bearer slot number.
	output logic [7:0] zd, // First signalling Z-bit, 0 when in TS1.
	output logic [1:0] pair, // Pair carrying the first bearer slot.
	output logic [5:0] pos // Position on that pair.
);

	wire [7:0] k = 8'({5'h0, sel}) + 8'h01;
	wire [7:0] kx2 = {k[6:0], 1'b0};
	wire [7:0] n8 = {5'h0, nba};
	wire [7:0] m8 = {6'h0, pairs_m1} + 8'h01;
	wire single = !mpair && (nba >= `IEOC_NBA_FSC);
	wire in_ts1 = single && (k + 8'h04 > n8);
	wire [7:0] nz = {n8[6:0], 1'b0} + {7'h0, fsc};
	wire [7:0] idx = nz + b1 - 8'h01;
	wire [7:0] rr = fsc ? idx - 8'h01 : idx;

	// Access k takes slots 2k-1, 2k (2k, 2k+1 without M-pair from four accesses) and Z-bits 2k, 2k+1 with Z1 taken.
	assign b1 = single ? kx2 : kx2 - 8'h01; // R01
	assign b2 = b1 + 8'h01; // R01
	assign zd = in_ts1 ? 8'h00 : (fsc ? kx2 : kx2 - 8'h01); // R01

	// Z-bits come before the slots; with fsc Z1 heads every pair, rest alternate.
	assign pair = mpair ? 2'(rr % m8) : 2'h0; // R03 R24
	assign pos = mpair ? 6'((rr / m8) + {7'h0, fsc}) : 6'(idx); // R02 R24

endmodule

`default_nettype wire

//--- hw/ieoc_top.sv
/*
 Remote-end basic-access signalling controller: parses requests, drives
 S-bus, loopback and reset controls per access, answers each request,
 sends S-bus notices and software requests, and maps access time slots.
 Assumes octet streams from an HDLC-like framer and an APB master.
*/
// Behaviour
// R01: Fast-signalling M-pair access k: slots 2k-1, 2k.
// R02: Z1 opens the sub-block on every pair.
// R03: Remaining Z-bits and slots alternate across pairs.
// R04: Messages ride operations or fast signalling channel.
// R05: More than four accesses force fast signalling.
// R06: Either end may originate messages itself.
// R07: Request: identifier 20, access nibble, code.
// R08: Response: same layout, identifier 148.
// R09: Access number is index minus one.
// R10: S-bus request codes 10 to 13.
// R11: Status request codes 00 to 03; the code refuses 03 with f4.
// R12: Maintenance request codes 30 to 3f.
// R13: Single-channel loop codes kept reserved; the code runs them when BLOOP_EN is set and the line is up.
// R14: S-bus response codes 90, d0, 91, d1, 92, 93.
// R15: Status response codes 80 to 83; the code sends 80 to 82 only.
// R16: Maintenance answers b or f nibble, same low.
// R17: Single-channel loops only while link active.
// R18: Loop success means S active, loop closed.
// R19: Each S-bus controlled by its access number.
// R20: Activate request activates and answers.
// R21: Deactivate request deactivates and answers.
// R22: Notice sent when S-bus state changes.
// R23: Termination reset clears only addressed access.
// R24: Z-bits first, then slots ascending.
// R25: Ignore low nibble; refuse unknown code or access.
// R26: Event out for received notices and failures.
`timescale 1ns/1ps
`default_nettype none
`include "ieoc_defs.svh"

module ieoc_top #(
	parameter int NBA = 6,
	parameter bit BLOOP_EN = 1'b0
) (
	input wire logic pclk, // Bus clock, 250 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic [7:0] rx_data, // Received octet.
	input wire logic rx_valid, // Received octet strobe.
	input wire logic rx_sof, // First received octet.
	output logic rx_ready, // Low while an answer waits.
	output logic [7:0] tx_data, // Transmit octet.
	output logic tx_valid, // Transmit octet valid.
	output logic tx_sof, // First transmit octet.
	input wire logic tx_ready, // Framer takes the octet.
	input wire logic link_up, // Line in data mode.
	input wire logic [NBA-1:0] sbus_up, // S-bus active per access.
	input wire logic [NBA-1:0] sbus_fail, // S-bus control failure.
	output logic [NBA-1:0] sbus_act, // Activate S-bus per access.
	output logic [NBA-1:0] loop2, // Full loop closed per access.
	output logic [NBA-1:0] loop_b1, // B1 loop per access.
	output logic [NBA-1:0] loop_b2, // B2 loop per access.
	output logic evt_valid, // Event pulse.
	output logic [3:0] evt_ba, // Event access number.
	output logic [7:0] evt_code, // Event message code.
	output logic fsc_route // Messages go on fast signalling.
);

	// ------------------------------------------------------------
	// Receive path
	// ------------------------------------------------------------
	ieoc_msg_if m ();

	ieoc_parse u_parse (
		.pclk(pclk),
		.presetn(presetn),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.rx_sof(rx_sof),
		.mo(m)
	);

	logic [10:0] ctrl_reg;
	logic resp_pend_reg;
	logic [7:0] rsp_code_reg;
	logic [3:0] rsp_ba_reg;
	logic sw_pend_reg;
	logic [7:0] sw_code_reg;
	logic [3:0] sw_ba_reg;
	logic [NBA-1:0] up_reg;
	logic [NBA-1:0] ntc_reg;
	logic [NBA-1:0] hitv;
	logic [NBA-1:0] chg;
	logic [NBA-1:0] act_next;
	logic [NBA-1:0] lp2_next;
	logic [NBA-1:0] lb1_next;
	logic [NBA-1:0] lb2_next;
	logic [NBA-1:0] ntc_next;
	ieoc_pkg::ieoc_tx_e st_reg;
	logic [3:0] tx_ba_reg;
	logic [7:0] tx_code_reg;
	logic [2:0] ntc_sel;
	logic ntc_any;

	// Message fields and access range check.
	wire [7:0] c = m.msg.code;
	wire [3:0] ba = m.msg.ba;
	wire [2:0] nba = ctrl_reg[2:0];
	wire is_req = m.valid && m.msg.id == `IEOC_ID_REQ; // R07
	wire is_rsp = m.valid && m.msg.id == `IEOC_ID_RSP; // R08
	wire ba_ok = ba < 4'(NBA) && ba < {1'b0, nba}; // R09
	wire [NBA-1:0] fsh = sbus_fail >> ba;
	wire fail_b = ba_ok && fsh[0];

	// Request code decode.
	wire q_on = c == `IEOC_C_SB_ON; // R10
	wire q_off = c == `IEOC_C_SB_OFF; // R10
	wire q_rst = c == `IEOC_C_RST; // R11
	wire q_sts = c == `IEOC_C_L2R || c == `IEOC_C_DEACT_INT; // R11
	wire q_lp2 = c == `IEOC_C_LP2; // R12
	wire q_lb1 = c == `IEOC_C_LPB1; // R12
	wire q_lb2 = c == `IEOC_C_LPB2; // R12
	wire q_rtn = c == `IEOC_C_RTN; // R12
	wire q_mnt = q_lp2 || q_lb1 || q_lb2 || q_rtn || c == `IEOC_C_HOLD;

	// Single-channel loops only when built in and the line is up.
	wire lb_ok = BLOOP_EN && link_up; // R13 R17
	wire lp_ok = q_lp2 ? !fail_b : ((q_lb1 || q_lb2) ? lb_ok : 1'b1);

	// Answer code for the request now decoded.
	wire [7:0] rsp_w = !ba_ok ? `IEOC_R_UTC : // R25
		(q_on || q_off) ? (fail_b ? {`IEOC_SFAIL_NIB, c[3:0]} : // R14
		c | `IEOC_RSP_BIT) : (q_rst || q_sts) ? c | `IEOC_RSP_BIT : // R15
		q_mnt ? {lp_ok ? `IEOC_OK_NIB : `IEOC_FAIL_NIB, c[3:0]} : // R16
		`IEOC_R_UTC; // R25

	// Received notices and failure answers become events.
	wire ev_w = (is_rsp && (c[7:6] == 2'h3 || c == (`IEOC_C_SB_UP |
		`IEOC_RSP_BIT) || c == (`IEOC_C_SB_DOWN | `IEOC_RSP_BIT))) ||
		(is_req && (c == `IEOC_C_SB_UP || c == `IEOC_C_SB_DOWN)); // R26

	// ------------------------------------------------------------
	// Per-access S-bus, loopback and notice state
	// ------------------------------------------------------------
	wire tk = st_reg == ieoc_pkg::tx_idle;
	wire take_rsp = tk && resp_pend_reg;
	wire take_sw = tk && !resp_pend_reg && sw_pend_reg; // R06
	wire take_ntc = tk && !resp_pend_reg && !sw_pend_reg && ntc_any;

	genvar gi;
	generate
		for (gi = 0; gi < NBA; gi++)
		begin : g_ba
			wire h = is_req && ba_ok && ba == 4'(gi); // R19
			assign hitv[gi] = h;
			assign chg[gi] = sbus_up[gi] ^ up_reg[gi]; // R22
			assign act_next[gi] = (h && (q_on || q_lp2) && !fail_b) ? 1'b1 :
				(h && (q_off || q_rst)) ? 1'b0 : sbus_act[gi]; // R20 R21 R23
			assign lp2_next[gi] = (h && q_lp2 && !fail_b) ? 1'b1 :
				(h && (q_rtn || q_rst || q_off)) ? 1'b0 : loop2[gi]; // R18 R23
			assign lb1_next[gi] = (h && q_lb1 && lb_ok) ? 1'b1 :
				(h && (q_rtn || q_rst)) || !link_up ? 1'b0 : loop_b1[gi]; // R17
			assign lb2_next[gi] = (h && q_lb2 && lb_ok) ? 1'b1 :
				(h && (q_rtn || q_rst)) || !link_up ? 1'b0 : loop_b2[gi]; // R17
			assign ntc_next[gi] = chg[gi] || (ntc_reg[gi] &&
				!(take_ntc && ntc_sel == 3'(gi))); // R22
		end
	endgenerate

	// Lowest pending notice is sent first.
	always_comb
	begin
		ntc_sel = 3'h0;
		ntc_any = 1'b0;
		for (int i = NBA - 1; i >= 0; i--)
		begin
			if (ntc_reg[i])
			begin
				ntc_sel = 3'(i);
				ntc_any = 1'b1;
			end
		end
	end

	// Per-access control registers and the notice queue.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sbus_act <= '0;
			loop2 <= '0;
			loop_b1 <= '0;
			loop_b2 <= '0;
			up_reg <= '0;
			ntc_reg <= '0;
		end
		else
		begin
			sbus_act <= act_next;
			loop2 <= lp2_next;
			loop_b1 <= lb1_next;
			loop_b2 <= lb2_next;
			up_reg <= sbus_up;
			ntc_reg <= ntc_next;
		end
	end

	// Answer and event capture; a new answer wins over its own release.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resp_pend_reg <= 1'b0;
			rsp_code_reg <= 8'h00;
			rsp_ba_reg <= 4'h0;
			evt_valid <= 1'b0;
			evt_ba <= 4'h0;
			evt_code <= 8'h00;
		end
		else
		begin
			resp_pend_reg <= is_req || (resp_pend_reg && !take_rsp);
			if (is_req)
			begin
				rsp_code_reg <= rsp_w;
				rsp_ba_reg <= ba;
			end
			evt_valid <= ev_w; // R26
			if (ev_w)
			begin
				evt_ba <= ba;
				evt_code <= c;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit sequencer
	// ------------------------------------------------------------
	wire [NBA-1:0] ush = up_reg >> ntc_sel;
	wire [7:0] ntc_code = ush[0] ? `IEOC_C_SB_UP : `IEOC_C_SB_DOWN; // R22
	wire [7:0] id_w = take_rsp ? `IEOC_ID_RSP : `IEOC_ID_REQ; // R07 R08
	wire [3:0] ba_w = take_rsp ? rsp_ba_reg :
		(take_sw ? sw_ba_reg : {1'b0, ntc_sel});
	wire [7:0] code_w = take_rsp ? rsp_code_reg :
		(take_sw ? sw_code_reg : ntc_code);
	wire go = take_rsp || take_sw || take_ntc;
	wire adv = tx_valid && tx_ready;

	// Three octets per message: identifier, access nibble, code.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= ieoc_pkg::tx_idle;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			tx_sof <= 1'b0;
			tx_ba_reg <= 4'h0;
			tx_code_reg <= 8'h00;
		end
		else
		begin
			case (st_reg)
				ieoc_pkg::tx_idle:
					if (go)
					begin
						st_reg <= ieoc_pkg::tx_id;
						tx_data <= id_w;
						tx_valid <= 1'b1;
						tx_sof <= 1'b1;
						tx_ba_reg <= ba_w;
						tx_code_reg <= code_w;
					end
				ieoc_pkg::tx_id:
					if (adv)
					begin
						st_reg <= ieoc_pkg::tx_ba;
						tx_data <= {tx_ba_reg, `IEOC_OCT2_PAD}; // R07
						tx_sof <= 1'b0;
					end
				ieoc_pkg::tx_ba:
					if (adv)
					begin
						st_reg <= ieoc_pkg::tx_code;
						tx_data <= tx_code_reg;
					end
				ieoc_pkg::tx_code:
					if (adv)
					begin
						st_reg <= ieoc_pkg::tx_idle;
						tx_valid <= 1'b0;
					end
				default:
					st_reg <= ieoc_pkg::tx_idle;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Slot map and register bus
	// ------------------------------------------------------------
	wire fsc_eff = ctrl_reg[`IEOC_CF_FSC] || nba > `IEOC_NBA_FSC; // R05
	logic [7:0] mb1;
	logic [7:0] mb2;
	logic [7:0] mzd;
	logic [1:0] mpr;
	logic [5:0] mps;

	ieoc_slotmap u_map (
		.fsc(fsc_eff),
		.mpair(ctrl_reg[`IEOC_CF_MPAIR]),
		.pairs_m1(ctrl_reg[6:5]),
		.nba(nba),
		.sel(ctrl_reg[10:8]),
		.b1(mb1),
		.b2(mb2),
		.zd(mzd),
		.pair(mpr),
		.pos(mps)
	);

	// Zero-wait slave: ready in the access phase, read data caught at setup.
	wire setup = psel && !penable && !pready;
	wire wr = psel && penable && pready && pwrite;
	wire a_ctl = paddr == `IEOC_A_CTRL;
	wire a_txc = paddr == `IEOC_A_TXC;
	wire a_ok = a_ctl || a_txc || paddr == `IEOC_A_STAT ||
		paddr == `IEOC_A_EVT || paddr == `IEOC_A_MAP;
	wire [31:0] stat_w = 32'({fsc_eff, resp_pend_reg, sw_pend_reg,
		ntc_reg, loop2, sbus_act});
	wire [31:0] rd_w = a_ctl ? {21'h0, ctrl_reg} :
		paddr == `IEOC_A_STAT ? stat_w :
		paddr == `IEOC_A_EVT ? {20'h0, evt_ba, evt_code} :
		a_txc ? {15'h0, sw_pend_reg, 4'h0, sw_ba_reg, sw_code_reg} :
		paddr == `IEOC_A_MAP ? {mps, mpr, mzd, mb2, mb1} : 32'h0;

	// Bus handshake and read data.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			if (setup)
			begin
				prdata <= pwrite ? 32'h0 : rd_w;
				pslverr <= !a_ok;
			end
		end
	end

	// Control and software request registers; pending request is kept.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= `IEOC_CTRL_RST;
			sw_pend_reg <= 1'b0;
			sw_code_reg <= 8'h00;
			sw_ba_reg <= 4'h0;
			rx_ready <= 1'b0;
			fsc_route <= 1'b0;
		end
		else
		begin
			if (wr && a_ctl)
				ctrl_reg <= pwdata[10:0];
			if (wr && a_txc && !sw_pend_reg)
			begin
				sw_code_reg <= pwdata[7:0];
				sw_ba_reg <= pwdata[11:8];
			end
			sw_pend_reg <= (wr && a_txc && !sw_pend_reg) || // R06
				(sw_pend_reg && !take_sw);
			rx_ready <= !(is_req || (resp_pend_reg && !take_rsp));
			fsc_route <= fsc_eff; // R04
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_head_id: assert property (tx_valid && tx_sof |-> tx_data == // R07
		`IEOC_ID_REQ || tx_data == `IEOC_ID_RSP)
		else $error("bad message identifier");
	a_oct2_pad: assert property (tx_valid && tx_sof && tx_ready |=> // R07
		!tx_sof && tx_data[3:0] == `IEOC_OCT2_PAD && tx_valid)
		else $error("octet two low nibble not zero");
	a_rsp_head: assert property (take_rsp |=> tx_sof && // R08
		tx_data == `IEOC_ID_RSP ##0 tx_ba_reg == $past(rsp_ba_reg))
		else $error("answer header wrong");
	a_bad_ba: assert property (is_req && !ba_ok |=> resp_pend_reg && // R25
		rsp_code_reg == `IEOC_R_UTC)
		else $error("bad access not refused");
	a_sbus_on: assert property (is_req && q_on && ba_ok && !fail_b |=> // R20
		(sbus_act & $past(hitv)) == $past(hitv) &&
		rsp_code_reg == 8'h90)
		else $error("activate not applied");
	a_rst_only: assert property (is_req && q_rst && ba_ok |=> // R23
		((sbus_act | loop2) & $past(hitv)) == '0 &&
		((sbus_act ^ $past(sbus_act)) & ~$past(hitv)) == '0)
		else $error("reset touched wrong access");
	a_ntc_set: assert property (chg != '0 |=> // R22
		(ntc_reg & $past(chg)) == $past(chg))
		else $error("notice not queued");
	a_fsc_force: assert property (nba > `IEOC_NBA_FSC |=> fsc_route) // R05
		else $error("fast signalling not forced");
	a_map_fsc: assert property (fsc_eff && ctrl_reg[`IEOC_CF_MPAIR] |-> // R01
		mb2 == mb1 + 8'h01 && mzd == mb1 + 8'h01)
		else $error("slot map wrong");

endmodule

`default_nettype wire

//--- test/ieoc_peer.sv
/*
 Model of the central-office transceiver at the far line end.
 Assumes the device's octet streams and a free-running bus clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ieoc_peer (
	input wire logic pclk, // Bus clock.
	input wire logic rx_ready, // Device can take a request.
	output logic [7:0] rx_data, // Octet to the device.
	output logic rx_valid, // Octet strobe.
	output logic rx_sof, // First octet of a message.
	input wire logic [7:0] tx_data, // Octet from the device.
	input wire logic tx_valid, // Device octet valid.
	input wire logic tx_sof, // Device first octet.
	output logic tx_ready // Octet taken.
);
	logic slow;
	logic [7:0] got[$];
	int sof_bad = 0;

	// Idle lines at time zero.
	initial
	begin
		slow = 1'b0;
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_sof = 1'b0;
		tx_ready = 1'b0;
	end

	// Takes device octets and counts misplaced first-octet marks; in slow
	// mode every other cycle stalls.
	always @(posedge pclk)
	begin
		if (tx_valid && tx_ready)
		begin
			if (tx_sof !== (got.size() % 3 == 0))
				sof_bad++;
			got.push_back(tx_data);
		end
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	// Sends one three-octet message once the device can take it.
	task automatic send(input logic [7:0] id, input logic [7:0] o2,
		input logic [7:0] code);
		logic [7:0] oct[3];
		oct = '{id, o2, code};
		@(posedge pclk);
		while (rx_ready !== 1'b1)
			@(posedge pclk);
		for (int i = 0; i < 3; i++)
		begin
			rx_data <= oct[i];
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			@(posedge pclk);
		end
		rx_valid <= 1'b0;
		rx_sof <= 1'b0;
		rx_data <= ~code;
	endtask
endmodule

`default_nettype wire

//--- test/isdn_ba_eoc_signalling_test.sv
/*
 Self-checking bench of the remote signalling controller.
 Assumes the peer model and the design files.
*/
`timescale 1ns/1ps
`default_nettype none

module isdn_ba_eoc_signalling_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic rx_valid, rx_sof, rx_ready, tx_valid, tx_sof, tx_ready;
	logic link_up, evt_valid, fsc_route;
	logic [7:0] paddr, rx_data, tx_data, evt_code;
	logic [3:0] evt_ba;
	logic [31:0] pwdata, prdata, q;
	logic [5:0] sbus_up, sbus_fail, sbus_act, loop2, loop_b1, loop_b2;
	int failures = 0;
	int tests_run = 0;
	int evt_n = 0;
	// Access octet, code, answer, fail, S-bus active, full loop.
	logic [47:0] tbl[18] = '{
		48'h00_10_90_00_01_00, 48'h50_10_90_00_21_00,
		48'h50_31_b1_00_21_20, 48'h50_00_80_00_01_00,
		48'h0f_11_91_00_00_00, 48'h00_31_b1_00_01_01,
		48'h00_3f_bf_00_01_00, 48'h00_01_81_00_01_00,
		48'h00_02_82_00_01_00, 48'h00_30_b0_00_01_00,
		48'h00_32_f2_00_01_00, 48'h00_33_f3_00_01_00,
		48'h00_03_f4_00_01_00, 48'h00_12_f4_00_01_00,
		48'h60_01_f4_00_01_00, 48'h00_55_f4_00_01_00,
		48'h00_11_d1_01_00_00, 48'h00_31_f1_01_00_00};

	ieoc_top #(.NBA(6), .BLOOP_EN(1'b0)) dut_u (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_data, .rx_valid, .rx_sof, .rx_ready, .tx_data, .tx_valid,
		.tx_sof, .tx_ready, .link_up, .sbus_up, .sbus_fail, .sbus_act,
		.loop2, .loop_b1, .loop_b2, .evt_valid, .evt_ba, .evt_code,
		.fsc_route);

	ieoc_peer peer_u (.pclk, .rx_ready, .rx_data, .rx_valid, .rx_sof,
		.tx_data, .tx_valid, .tx_sof, .tx_ready);

	// Counts event pulses in the cycle in which they stand.
	always @(posedge pclk)
		if (evt_valid === 1'b1)
			evt_n++;

	// Bus clock, 4 ns period.
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("tests %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Compares one value.
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// One APB transfer; the request holds until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Waits for a three-octet message from the device and compares it.
	task automatic msg3(input logic [23:0] e);
		logic [23:0] m;
		int n;
		n = 0;
		m = 24'h0;
		while (peer_u.got.size() < 3 && n < 300)
		begin
			n++;
			@(posedge pclk);
		end
		if (peer_u.got.size() < 3)
			chk("wait", 32'h3, 32'(peer_u.got.size()));
		else
		begin
			for (int i = 0; i < 3; i++)
				m = {m[15:0], peer_u.got.pop_front()};
			chk("msg", {8'h00, e}, {8'h00, m});
		end
	endtask

	// Cuts a hang short.
	initial
	begin
		#200000;
		failures++;
		results();
	end

	// Main sequence.
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{sbus_up, sbus_fail} = '0;
		link_up = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h001, q);
		apb(1'b0, 8'h14, 32'h0);
		chk("err", 32'h1, {31'h0, pslverr});
		apb(1'b1, 8'h00, 32'h6);
		repeat (2) @(posedge pclk);
		chk("fsc", 32'h1, {31'h0, fsc_route});
		foreach (tbl[i])
		begin
			sbus_fail <= {6{tbl[i][16]}};
			peer_u.slow = i[0];
			peer_u.send(8'h14, tbl[i][47:40], tbl[i][39:32]);
			msg3({8'h94, tbl[i][47:44], 4'h0, tbl[i][31:24]});
			chk("act", {26'h0, tbl[i][13:8]}, {26'h0, sbus_act});
			chk("loop", {26'h0, tbl[i][5:0]}, {26'h0, loop2});
			chk("lpb", 32'h0, {26'h0, loop_b1 | loop_b2});
		end
		chk("evt", 32'h012, {20'h0, evt_ba, evt_code});
		peer_u.send(8'h94, 8'h20, 8'hd0);
		repeat (3) @(posedge pclk);
		chk("evt2", 32'h2d0, {20'h0, evt_ba, evt_code});
		apb(1'b0, 8'h08, 32'h0);
		chk("evtreg", 32'h2d0, q);
		sbus_fail <= 6'h00;
		sbus_up <= 6'h04;
		msg3(24'h14_20_12);
		sbus_up <= 6'h00;
		msg3(24'h14_20_13);
		apb(1'b1, 8'h0c, 32'h0000_0301);
		msg3(24'h14_30_01);
		apb(1'b0, 8'h0c, 32'h0);
		chk("txc", 32'h0, {31'h0, q[16]});
		for (int k = 1; k <= 6; k++)
		begin
			apb(1'b1, 8'h00, 32'h3e | (32'(k - 1) << 8));
			apb(1'b0, 8'h10, 32'h0);
			chk("map", {6'(k + 6), 2'h0, 8'(2 * k), 8'(2 * k), 8'(2 * k - 1)},
				q);
		end
		chk("evtn", 32'h2, 32'(evt_n));
		chk("sof", 32'h0, 32'(peer_u.sof_bad));
		results();
	end
endmodule

`default_nettype wire
